// ---- inc/sps_map.svh ----
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// Selection codes
`define SPS_CODE_FIFO_THR    6'h02
`define SPS_CODE_FIFO_FULL   6'h03
`define SPS_CODE_UNDERFLOW   6'h05
`define SPS_CODE_PACKET      6'h06
`define SPS_CODE_PLL_LOCK    6'h0A
`define SPS_CODE_SERIAL_CLK  6'h0B
`define SPS_CODE_AMP_EN      6'h1B
`define SPS_CODE_CHIP_RDY    6'h29
`define SPS_CODE_XTAL_OK     6'h2B
`define SPS_CODE_HIZ         6'h2E
`define SPS_CODE_CONST       6'h2F
`define SPS_CODE_CLK_BASE    6'h30

// Configuration layout and reset values
`define SPS_CFG_A_RESET      8'h3F
`define SPS_CFG_B_RESET      8'h2E
`define SPS_CFG_ANALOG       8'h80
`define SPS_BIT_ANALOG       7
`define SPS_BIT_INVERT       6

// Divider layout
`define SPS_NUM_CLK          16
`define SPS_DIV_POW_W        7
`define SPS_DIV_TRI_W        6
`define SPS_DIV_SLOWEST      192

`endif

// ---- inc/sps_pkg.sv ----
package sps_pkg;

    typedef logic [5:0] sps_code_t;
    typedef logic [7:0] sps_cfg_t;

    typedef enum logic [1:0] {
        SPS_DRIVE_LEVEL,
        SPS_DRIVE_HIZ,
        SPS_DRIVE_FAST
    } sps_drive_t;

endpackage

// ---- hdl/sps_clk_div.sv ----
`timescale 1ns/1ps
`include "sps_map.svh"

module sps_clk_div (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    output wire logic [`SPS_NUM_CLK-1:0] div_clk
);

    logic [`SPS_DIV_POW_W-1:0] pow_count;
    logic [1:0]                tri_phase;
    logic [`SPS_DIV_TRI_W-1:0] tri_count;
    logic                      third;
    logic                      half_pos;
    logic                      half_neg;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pow_count <= '0;
        end else begin
            pow_count <= pow_count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tri_phase <= 2'h0;
            tri_count <= '0;
            third     <= 1'b0;
            half_pos  <= 1'b0;
        end else begin
            tri_phase <= (tri_phase == 2'h2) ? 2'h0 : tri_phase + 2'h1;
            if (tri_phase == 2'h2) begin
                tri_count <= tri_count + 1'b1;
            end
            third    <= (tri_phase == 2'h2);
            half_pos <= (tri_phase == 2'h2);
        end
    end

    // Divide by 1.5 needs both edges; the clock gates the two halves, so
    // this output carries clock-path skew and is not glitch-checked.
    always_ff @(negedge clock) begin
        if (!resetn) begin
            half_neg <= 1'b0;
        end else begin
            half_neg <= (tri_phase == 2'h1);
        end
    end

    assign div_clk[0] = clock;
    assign div_clk[1] = (half_pos & clock) | (half_neg & ~clock);
    assign div_clk[3] = third;

    for (genvar i = 0; i < `SPS_DIV_POW_W; i++) begin : g_div
        assign div_clk[2*i+2] = pow_count[i];
        if (i < `SPS_DIV_TRI_W) begin : g_tri
            assign div_clk[2*i+5] = tri_count[i];
        end
    end

    property p_div_slowest;
        @(posedge clock) disable iff (!resetn)
        $rose(div_clk[15]) |-> ##192 $rose(div_clk[15]);
    endproperty
    a_div_slowest: assert property (p_div_slowest)
        else $error("Slowest divided clock period is not 192 cycles");

    property p_div_three;
        @(posedge clock) disable iff (!resetn)
        $rose(div_clk[3]) |=> !div_clk[3] ##1 !div_clk[3] ##1 $rose(div_clk[3]);
    endproperty
    a_div_three: assert property (p_div_three)
        else $error("Divide by three output has wrong period");

endmodule // sps_clk_div

// ---- hdl/sps_pin_select.sv ----
// Functional notes
// - Two output pins, each steered by its own 6-bit selection code.
// - Pin B doubles as SPI data out; status valid only while select high.
// - Pin B selects high impedance after reset.
// - Pin A selects crystal clock divided by 192 after reset.
// - Writing 128 to pin A config hands the pin to the temperature sensor.
// - Code 2 follows transmit FIFO at-or-above-threshold level.
// - Code 3 rises on FIFO full, holds until fill drops below threshold.
// - Code 5 rises on FIFO underflow, holds until the FIFO is flushed.
// - Code 6 rises after sync word, falls at packet end or underflow.
// - Code 10 shows PLL lock; host watches it as an interrupt.
// - Code 11 shows the synchronous serial data clock.
// - Code 27 shows amplifier enable state.
// - Code 46 is high impedance; code 47 is constant low, inverted gives high.
// - Codes 48 to 63 give crystal clock divided by 1 up to 192.
`timescale 1ns/1ps
`include "sps_map.svh"

module sps_pin_select (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                pin_a_config_write,
    input  wire logic [7:0]          pin_a_config_data,
    input  wire logic                pin_b_config_write,
    input  wire logic [7:0]          pin_b_config_data,
    input  wire logic                tx_fifo_at_threshold,
    input  wire logic                tx_fifo_full,
    input  wire logic                tx_fifo_underflow,
    input  wire logic                tx_fifo_flush,
    input  wire logic                sync_word_sent,
    input  wire logic                packet_end,
    input  wire logic                pll_lock_pin,
    input  wire logic                serial_data_clock,
    input  wire logic                amp_enable_state,
    input  wire logic                chip_ready_low,
    input  wire logic                crystal_settled,
    input  wire logic                spi_csn_pin,
    input  wire logic                spi_so_data,
    input  wire logic                spi_so_enable,
    output wire logic                status_pin_a_out,
    output wire logic                status_pin_a_oe,
    output wire logic                status_pin_b_out,
    output wire logic                status_pin_b_oe,
    output wire logic                temp_sensor_enable,
    output sps_pkg::sps_cfg_t        pin_a_config,
    output sps_pkg::sps_cfg_t        pin_b_config
);

    logic [1:0]                sync1;
    logic [1:0]                sync2;
    logic [1:0]                sync3;
    logic [1:0]                pin_level;
    logic                      pll_locked;
    logic                      csn_high;
    logic                      fill_full_flag;
    logic                      underflow_flag;
    logic                      packet_flag;
    logic [`SPS_NUM_CLK-1:0]   div_clk;
    sps_pkg::sps_cfg_t         cfg [2];
    wire logic [1:0]           drv_level;
    wire logic [1:0]           drv_oe;
    wire logic [1:0]           drv_fast;
    wire logic [1:0]           fast_val;

    // Configuration; pin B has no analog path, so its top bit stays clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_a_config <= `SPS_CFG_A_RESET;
        end else if (pin_a_config_write) begin
            pin_a_config <= pin_a_config_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_b_config <= `SPS_CFG_B_RESET;
        end else if (pin_b_config_write) begin
            pin_b_config <= {1'b0, pin_b_config_data[6:0]};
        end
    end

    assign temp_sensor_enable = pin_a_config[`SPS_BIT_ANALOG];
    assign cfg[0] = pin_a_config;
    assign cfg[1] = pin_b_config;

    // Pin inputs: bit 1 SPI select, bit 0 PLL lock; level moves once
    // the second and third stages agree
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1     <= 2'h2;
            sync2     <= 2'h2;
            sync3     <= 2'h2;
            pin_level <= 2'h2;
        end else begin
            sync1 <= {spi_csn_pin, pll_lock_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int k = 0; k < 2; k++) begin
                if (sync2[k] == sync3[k]) begin
                    pin_level[k] <= sync3[k];
                end
            end
        end
    end

    assign pll_locked = pin_level[0];
    assign csn_high   = pin_level[1];

    // Event flags; a set in the same cycle as its release wins
    always_ff @(posedge clock) begin
        if (!resetn) begin
            fill_full_flag <= 1'b0;
        end else if (tx_fifo_full) begin
            fill_full_flag <= 1'b1;
        end else if (!tx_fifo_at_threshold) begin
            fill_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            underflow_flag <= 1'b0;
        end else if (tx_fifo_underflow) begin
            underflow_flag <= 1'b1;
        end else if (tx_fifo_flush) begin
            underflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            packet_flag <= 1'b0;
        end else if (sync_word_sent) begin
            packet_flag <= 1'b1;
        end else if (packet_end || tx_fifo_underflow) begin
            packet_flag <= 1'b0;
        end
    end

    sps_clk_div u_clk_div (
        .clock   (clock),
        .resetn  (resetn),
        .div_clk (div_clk)
    );

    for (genvar i = 0; i < 2; i++) begin : g_pin
        sps_pkg::sps_code_t  code;
        sps_pkg::sps_drive_t kind;
        logic                raw;
        logic                invert;
        logic                analog;
        logic                q_level;
        logic                q_oe;
        logic                q_fast;

        assign code   = cfg[i][5:0];
        assign invert = cfg[i][`SPS_BIT_INVERT];
        assign analog = cfg[i][`SPS_BIT_ANALOG];

        always_comb begin
            raw  = 1'b0;
            kind = sps_pkg::SPS_DRIVE_LEVEL;
            case (code)
                `SPS_CODE_FIFO_THR:   raw = tx_fifo_at_threshold;
                `SPS_CODE_FIFO_FULL:  raw = fill_full_flag;
                `SPS_CODE_UNDERFLOW:  raw = underflow_flag;
                `SPS_CODE_PACKET:     raw = packet_flag;
                `SPS_CODE_PLL_LOCK:   raw = pll_locked;
                `SPS_CODE_SERIAL_CLK: raw = serial_data_clock;
                `SPS_CODE_AMP_EN:     raw = amp_enable_state;
                `SPS_CODE_CHIP_RDY:   raw = chip_ready_low;
                `SPS_CODE_XTAL_OK:    raw = crystal_settled;
                `SPS_CODE_HIZ:        kind = sps_pkg::SPS_DRIVE_HIZ;
                `SPS_CODE_CONST:      raw = 1'b0;
                default: begin
                    if (code >= `SPS_CODE_CLK_BASE) begin
                        raw = div_clk[code[3:0]];
                        if (code[3:1] == 3'h0) begin
                            kind = sps_pkg::SPS_DRIVE_FAST;
                        end
                    end
                end
            endcase
        end

        // Registered drive keeps the pin free of mux glitches; only the
        // two fastest clocks bypass it, trading a clean edge for rate
        always_ff @(posedge clock) begin
            if (!resetn) begin
                q_level <= 1'b0;
                q_oe    <= 1'b0;
                q_fast  <= 1'b0;
            end else begin
                q_level <= raw ^ invert;
                q_oe    <= (kind != sps_pkg::SPS_DRIVE_HIZ) && !analog;
                q_fast  <= (kind == sps_pkg::SPS_DRIVE_FAST);
            end
        end

        assign drv_level[i] = q_level;
        assign drv_oe[i]    = q_oe;
        assign drv_fast[i]  = q_fast;
        assign fast_val[i]  = div_clk[code[3:0]] ^ invert;
    end

    assign status_pin_a_out = drv_fast[0] ? fast_val[0] : drv_level[0];
    assign status_pin_a_oe  = drv_oe[0];
    // SPI owns pin B while selected
    assign status_pin_b_out = csn_high ? (drv_fast[1] ? fast_val[1] : drv_level[1])
                                       : spi_so_data;
    assign status_pin_b_oe  = csn_high ? drv_oe[1] : spi_so_enable;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_a_reset;
        $rose(resetn) |-> pin_a_config == `SPS_CFG_A_RESET && !temp_sensor_enable;
    endproperty
    a_a_reset: assert property (p_a_reset)
        else $error("Pin A config not at divided clock after reset");

    property p_b_reset;
        $rose(resetn) |-> pin_b_config == `SPS_CFG_B_RESET ##1 !drv_oe[1];
    endproperty
    a_b_reset: assert property (p_b_reset)
        else $error("Pin B not high impedance after reset");

    property p_cfg_write;
        (pin_b_config_write && !pin_a_config_write) |=>
            pin_b_config[6:0] == $past(pin_b_config_data[6:0]) && $stable(pin_a_config);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("Pin B config write not independent");

    property p_analog;
        (pin_a_config_write && pin_a_config_data == `SPS_CFG_ANALOG) |=>
            temp_sensor_enable ##1 !status_pin_a_oe;
    endproperty
    a_analog: assert property (p_analog)
        else $error("Analog select did not release pin A");

    property p_thr;
        (pin_a_config[5:0] == `SPS_CODE_FIFO_THR && !pin_a_config[`SPS_BIT_INVERT])
            |=> status_pin_a_out == $past(tx_fifo_at_threshold);
    endproperty
    a_thr: assert property (p_thr)
        else $error("Threshold code does not follow FIFO level");

    property p_full;
        (tx_fifo_full || (fill_full_flag && tx_fifo_at_threshold)) |=> fill_full_flag;
    endproperty
    a_full: assert property (p_full)
        else $error("Full flag lost before fill fell below threshold");

    property p_uflow;
        (tx_fifo_underflow || (underflow_flag && !tx_fifo_flush)) |=> underflow_flag;
    endproperty
    a_uflow: assert property (p_uflow)
        else $error("Underflow flag lost before flush");

    property p_pkt;
        (packet_flag && (packet_end || tx_fifo_underflow) && !sync_word_sent)
            |=> !packet_flag;
    endproperty
    a_pkt: assert property (p_pkt)
        else $error("Packet flag not cleared at end or underflow");

    property p_lock;
        (pin_a_config[5:0] == `SPS_CODE_PLL_LOCK && !pin_a_config[`SPS_BIT_INVERT])
            |=> status_pin_a_out == $past(pll_locked);
    endproperty
    a_lock: assert property (p_lock)
        else $error("Lock code does not show filtered lock");

    property p_const;
        (pin_a_config[5:0] == `SPS_CODE_CONST && !pin_a_config[`SPS_BIT_ANALOG])
            |=> status_pin_a_oe && status_pin_a_out == $past(pin_a_config[6]);
    endproperty
    a_const: assert property (p_const)
        else $error("Constant code not driven at inversion level");

    property p_spi;
        $fell(spi_csn_pin) ##1 !spi_csn_pin ##1 !spi_csn_pin ##1 !spi_csn_pin
            |=> status_pin_b_oe == spi_so_enable && status_pin_b_out == spi_so_data;
    endproperty
    a_spi: assert property (p_spi)
        else $error("SPI did not take pin B while selected");

endmodule // sps_pin_select

// ---- verification/sps_host_model.sv ----
`timescale 1ns/1ps

module sps_host_model (
    input  wire logic        clock,
    input  wire logic        pin_a_out,
    input  wire logic        pin_a_oe,
    input  wire logic        pin_b_out,
    input  wire logic        pin_b_oe,
    input  wire logic        spi_csn_pin,
    output logic      [15:0] irq_a_count,
    output logic      [15:0] irq_b_count
);
    logic a_last;
    logic b_last;
    logic a_lvl;
    logic b_lvl;

    // No pull on either pin, so an undriven pin shows the inverse of its last level
    assign a_lvl = pin_a_oe ? pin_a_out : ~a_last;
    assign b_lvl = pin_b_oe ? pin_b_out : ~b_last;

    initial begin
        a_last      = 1'b0;
        b_last      = 1'b0;
        irq_a_count = 16'h0000;
        irq_b_count = 16'h0000;
    end

    // Rising level is an interrupt; floating noise is never counted
    always @(posedge clock) begin
        if (pin_a_oe && a_lvl && !a_last) begin
            irq_a_count <= irq_a_count + 16'h0001;
        end
        // Pin B carries status only while select is high
        if (pin_b_oe && spi_csn_pin && b_lvl && !b_last) begin
            irq_b_count <= irq_b_count + 16'h0001;
        end
        a_last <= a_lvl;
        b_last <= b_lvl;
    end
endmodule // sps_host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "sps_map.svh"

module tb_top;
    logic              clock  = 1'b0;
    logic              resetn = 1'b0;
    logic              wa     = 1'b0;
    logic              wb     = 1'b0;
    logic        [7:0] da     = 8'h00;
    logic        [7:0] db     = 8'h00;
    logic        [4:0] src    = 5'h00;
    logic        [4:0] ev     = 5'h00;
    logic              pll    = 1'b0;
    logic              csn    = 1'b1;
    logic              so_d   = 1'b0;
    logic              so_e   = 1'b0;
    wire logic         a_out, a_oe, b_out, b_oe, temp_en;
    sps_pkg::sps_cfg_t cfg_a, cfg_b;
    logic       [15:0] irq_a, irq_b, p, n0, n1;
    int                err_total = 0;
    int                n_compared = 0;
    int                cyc = 0;
    int                dv[16] = '{1, 1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192};
    logic        [5:0] lc[5] = '{6'h02, 6'h0B, 6'h1B, 6'h29, 6'h2B};

    always #12.5 clock = ~clock;

    sps_pin_select DUT (
        .clock(clock), .resetn(resetn),
        .pin_a_config_write(wa), .pin_a_config_data(da),
        .pin_b_config_write(wb), .pin_b_config_data(db),
        .tx_fifo_at_threshold(src[0]), .tx_fifo_full(ev[0]),
        .tx_fifo_underflow(ev[1]), .tx_fifo_flush(ev[2]),
        .sync_word_sent(ev[3]), .packet_end(ev[4]), .pll_lock_pin(pll),
        .serial_data_clock(src[1]), .amp_enable_state(src[2]),
        .chip_ready_low(src[3]), .crystal_settled(src[4]),
        .spi_csn_pin(csn), .spi_so_data(so_d), .spi_so_enable(so_e),
        .status_pin_a_out(a_out), .status_pin_a_oe(a_oe),
        .status_pin_b_out(b_out), .status_pin_b_oe(b_oe),
        .temp_sensor_enable(temp_en), .pin_a_config(cfg_a), .pin_b_config(cfg_b));

    sps_host_model host (
        .clock(clock), .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out),
        .pin_b_oe(b_oe), .spi_csn_pin(csn), .irq_a_count(irq_a), .irq_b_count(irq_b));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task st(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task ca(input logic e);
        chk(16'(a_out), 16'(e));
    endtask

    // Pulse is one cycle; outputs settle two cycles later, so three is safe
    task wr(input logic b, input logic [7:0] d);
        @(posedge clock);
        wa <= ~b;
        wb <= b;
        da <= d;
        db <= d;
        @(posedge clock);
        wa <= 1'b0;
        wb <= 1'b0;
        st(3);
    endtask

    task pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
        st(3);
    endtask

    task setsrc(input int i, input logic v);
        @(posedge clock);
        src[i] <= v;
        st(3);
    endtask

    // Cycles between two rising samples of pin A
    task per(output logic [15:0] n);
        n = 16'h0000;
        while (a_out !== 1'b0 && n < 400) begin
            st(1);
            n++;
        end
        while (a_out !== 1'b1 && n < 800) begin
            st(1);
            n++;
        end
        n = 16'h0000;
        do begin
            st(1);
            n++;
        end while (a_out !== 1'b0 && n < 400);
        while (a_out !== 1'b1 && n < 400) begin
            st(1);
            n++;
        end
    endtask

    task t_reset;
        st(3);
        chk(16'(cfg_a), 16'(`SPS_CFG_A_RESET));
        chk(16'(cfg_b), 16'(`SPS_CFG_B_RESET));
        chk(16'(b_oe), 16'h0000);
        chk(16'(a_oe), 16'h0001);
        per(p);
        chk(p, 16'h00C0);
    endtask

    task t_level;
        for (int k = 0; k < 5; k++) begin
            for (int v = 0; v < 2; v++) begin
                wr(1'b0, {1'b0, 1'(v), lc[k]});
                setsrc(k, 1'b1);
                ca(1'(!v));
                setsrc(k, 1'b0);
                ca(1'(v));
            end
        end
    endtask

    task t_flags;
        wr(1'b0, 8'h03);
        setsrc(0, 1'b1);
        ca(1'b0);
        pulse(0);
        ca(1'b1);
        st(4);
        ca(1'b1);
        setsrc(0, 1'b0);
        ca(1'b0);
        wr(1'b0, 8'h05);
        pulse(1);
        st(4);
        ca(1'b1);
        pulse(2);
        ca(1'b0);
        wr(1'b0, 8'h06);
        pulse(3);
        ca(1'b1);
        pulse(4);
        ca(1'b0);
        pulse(3);
        ca(1'b1);
        pulse(1);
        ca(1'b0);
        pulse(2);
    endtask

    // Lock goes through a synchroniser, so allow six cycles
    task t_pll;
        wr(1'b0, 8'h0A);
        wr(1'b1, 8'h0A);
        n0 = irq_b;
        n1 = irq_a;
        @(posedge clock);
        pll <= 1'b1;
        st(6);
        chk(16'(b_out), 16'h0001);
        ca(1'b1);
        chk(irq_b, n0 + 16'h0001);
        chk(irq_a, n1 + 16'h0001);
        @(posedge clock);
        pll <= 1'b0;
        st(6);
        chk(16'(b_out), 16'h0000);
        ca(1'b0);
    endtask

    task t_const;
        wr(1'b0, 8'h2E);
        chk(16'(a_oe), 16'h0000);
        wr(1'b0, 8'h2F);
        ca(1'b0);
        chk(16'(a_oe), 16'h0001);
        wr(1'b0, 8'h6F);
        ca(1'b1);
        wr(1'b0, 8'h00);
        ca(1'b0);
        wr(1'b0, 8'h4D);
        ca(1'b1);
    endtask

    task t_spi;
        wr(1'b1, 8'h6F);
        @(posedge clock);
        csn <= 1'b0;
        so_e <= 1'b1;
        st(6);
        chk(16'(b_out), 16'h0000);
        chk(16'(b_oe), 16'h0001);
        @(posedge clock);
        so_d <= 1'b1;
        so_e <= 1'b0;
        st(1);
        chk(16'(b_oe), 16'h0000);
        @(posedge clock);
        csn <= 1'b1;
        so_d <= 1'b0;
        st(6);
        chk(16'(b_out), 16'h0001);
        chk(16'(b_oe), 16'h0001);
    endtask

    // Codes 48 and 49 bypass the output register, so period is only measured from 50
    task t_div;
        wr(1'b1, 8'h2F);
        wr(1'b0, 8'h30);
        ca(1'b1);
        #12.5;
        ca(1'b0);
        wr(1'b0, 8'h31);
        n0 = 16'h0000;
        repeat (6) begin
            n0 = n0 + 16'(a_out);
            #12.5;
        end
        chk(n0, 16'h0002);
        for (int c = 50; c < 64; c++) begin
            wr(1'b0, {2'b00, 6'(c)});
            per(p);
            chk(p, 16'(dv[c - 48]));
        end
        chk(16'(cfg_b), 16'h002F);
    endtask

    task t_analog;
        wr(1'b0, 8'h80);
        chk(16'(cfg_a), 16'h0080);
        chk(16'(temp_en), 16'h0001);
        chk(16'(a_oe), 16'h0000);
        wr(1'b1, 8'hAE);
        chk(16'(cfg_b), 16'h002E);
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude;
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        t_reset;
        t_level;
        t_flags;
        t_pll;
        t_const;
        t_spi;
        t_div;
        t_analog;
        conclude;
    end
endmodule // tb_top
